// ===== hw/sicr_regs.sv
// Configuration registers, SPI slave and wetting timers of switch inputs
// Summary of operation
// - Overvoltage without bypass caps all wetting to low level, blocks low power
// - Check bit clear: ignore wake pin in low power while io rail low
// - Check bit set (default): wake on any wake pin falling edge in low power
// - Interrupt pin style bit: 0 holds pin low, 1 pulses it low
// - Mux method field bits 9-8: 00/01 SPI, 10 hw 2-bit, 11 hw 3-bit
// - Bits 7-0 choose battery (1) or ground (0) sensing, default battery
// - Tri-state bit turns input current source off, comparator stays on
// - Tri-stated inputs still sampled at polls with source off
// - Change of state and wake decision made at end of poll window
// - Tri-state bits reset to 1, unused bits read 0
// - Each input has a 3-bit wetting level field, reset 110
// - Level codes 000..111 map 2,6,8,10,12,14,16,20 mA
// - Each input has its own 20 ms timer started at threshold crossing
// - Expired timer in pulsed mode drops source to sustain level
// - Continuous bit 1 keeps full level, 0 gives pulsed operation
// - Continuous bits reset to 0
// - Next transfer after a write returns new value with its address
`timescale 1ns/10ps
`default_nettype none
`include "sicr_map.svh"
module sicr_regs #(
	parameter int NUM_IN   = 22,
	parameter int WET_CYC  = `SICR_WET_CYCLES
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_n_i,
	input  wire logic                spi_sclk_i,
	input  wire logic                spi_cs_n_i,
	input  wire logic                spi_mosi_i,
	output logic                     spi_miso_o,
	input  wire logic [NUM_IN-1:0]   switch_cmp_i,
	input  wire logic                battery_overvoltage_i,
	input  wire logic                io_supply_rail_i,
	input  wire logic                low_power_state_i,
	input  wire logic                low_power_req_i,
	input  wire logic                poll_active_i,
	input  wire logic                wake_pin_i,
	input  wire logic                irq_event_i,
	output logic                     irq_pin_o,
	output logic                     irq_pin_oe_n_o,
	output logic                     wake_req_o,
	output logic                     low_power_allow_o,
	output sicr_pkg::sicr_mux_e      analog_mux_mode_o,
	output logic [7:0]               switch_to_battery_o,
	output logic [NUM_IN-1:0]        source_on_o,
	output sicr_pkg::sicr_level_t    level_o [NUM_IN]
);
	import sicr_pkg::*;

	localparam int NP = 8;
	localparam int TW = $clog2(WET_CYC + 1);

	// Synchronisers for asynchronous inputs except low_power_req_i and irq_event_i
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic [NUM_IN-1:0] cmp_a;
	logic [NUM_IN-1:0] cmp_b;
	logic [2:0] misc_a;
	logic [2:0] misc_b;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a <= 5'h1e;
			sync_b <= 5'h1e;
			cmp_a  <= '0;
			cmp_b  <= '0;
			misc_a <= 3'h0;
			misc_b <= 3'h0;
		end else begin
			sync_a <= {wake_pin_i, spi_cs_n_i, io_supply_rail_i,
				battery_overvoltage_i, spi_sclk_i};
			sync_b <= sync_a;
			cmp_a  <= switch_cmp_i;
			cmp_b  <= cmp_a;
			misc_a <= {low_power_state_i, poll_active_i, spi_mosi_i};
			misc_b <= misc_a;
		end
	end
	wire logic sclk_s = sync_b[0];
	wire logic ov_s   = sync_b[1];
	wire logic rail_s = sync_b[2];
	wire logic cs_n_s = sync_b[3];
	wire logic wake_s = sync_b[4];
	wire logic mosi_s = misc_b[0];
	wire logic poll_s = misc_b[1];
	wire logic lps_s  = misc_b[2];

	// Edge detection on the sampled SPI clock and select
	logic sclk_q;
	logic cs_q;
	logic wake_q;
	logic poll_q;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			wake_q <= 1'b1;
			poll_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			cs_q   <= cs_n_s;
			wake_q <= wake_s;
			poll_q <= poll_s;
		end
	end
	wire logic sclk_rise = sclk_s & ~sclk_q;
	wire logic sclk_fall = ~sclk_s & sclk_q;
	wire logic cs_fall   = ~cs_n_s & cs_q;
	wire logic cs_rise   = cs_n_s & ~cs_q;

	// Registers
	logic [23:0] reg_global;
	logic [23:0] reg_tri_p;
	logic [23:0] reg_tri_g;
	logic [23:0] reg_wet_p;
	logic [23:0] reg_wet_gl;
	logic [23:0] reg_wet_gh;
	logic [23:0] reg_cont_p;
	logic [23:0] reg_cont_g;

	// SPI shifter: 32 bits, MSB first, sampled on rising SCLK
	logic [31:0] rx_shift;
	logic [31:0] tx_shift;
	logic [5:0]  bit_cnt;
	logic [31:0] reply;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_shift <= 32'h0000_0000;
			bit_cnt  <= 6'h00;
		end else if (cs_fall) begin
			bit_cnt <= 6'h00;
		end else if (!cs_n_s && sclk_rise) begin
			rx_shift <= {rx_shift[30:0], mosi_s};
			bit_cnt  <= bit_cnt + 6'h01;
		end
	end
	wire logic word_done = cs_rise && (bit_cnt == 6'h20);
	wire logic [6:0]  cmd_addr = rx_shift[31:25];
	wire logic        cmd_wr   = rx_shift[24];
	wire logic [23:0] cmd_data = rx_shift[23:0];

	// Read-back value of an address; unused bits read zero
	function automatic logic [23:0] read_reg(input logic [6:0] a);
		case (a)
			`SICR_ADDR_GLOBAL:    read_reg = reg_global;
			`SICR_ADDR_TRI_PROG:  read_reg = reg_tri_p;
			`SICR_ADDR_TRI_GND:   read_reg = reg_tri_g;
			`SICR_ADDR_WET_PROG:  read_reg = reg_wet_p;
			`SICR_ADDR_WET_GLO:   read_reg = reg_wet_gl;
			`SICR_ADDR_WET_GHI:   read_reg = reg_wet_gh;
			`SICR_ADDR_CONT_PROG: read_reg = reg_cont_p;
			`SICR_ADDR_CONT_GND:  read_reg = reg_cont_g;
			7'h00:                read_reg = `SICR_SPI_CHECK_WORD;
			default:              read_reg = 24'h00_0000;
		endcase
	endfunction

	// Register writes take effect when select rises after 32 bits
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_global <= `SICR_RST_GLOBAL;
			reg_tri_p  <= `SICR_RST_TRI_PROG;
			reg_tri_g  <= `SICR_RST_TRI_GND;
			reg_wet_p  <= `SICR_RST_WET;
			reg_wet_gl <= `SICR_RST_WET;
			reg_wet_gh <= `SICR_RST_WET_GHI;
			reg_cont_p <= `SICR_RST_CONT;
			reg_cont_g <= `SICR_RST_CONT;
		end else if (word_done && cmd_wr) begin
			case (cmd_addr)
				`SICR_ADDR_GLOBAL:
					reg_global <= cmd_data & `SICR_MASK_GLOBAL;
				`SICR_ADDR_TRI_PROG:
					reg_tri_p <= cmd_data & `SICR_MASK_PROG;
				`SICR_ADDR_TRI_GND:
					reg_tri_g <= cmd_data & `SICR_MASK_GND;
				`SICR_ADDR_WET_PROG:  reg_wet_p  <= cmd_data;
				`SICR_ADDR_WET_GLO:   reg_wet_gl <= cmd_data;
				`SICR_ADDR_WET_GHI:
					reg_wet_gh <= cmd_data & `SICR_MASK_WET_GHI;
				`SICR_ADDR_CONT_PROG:
					reg_cont_p <= cmd_data & `SICR_MASK_PROG;
				`SICR_ADDR_CONT_GND:
					reg_cont_g <= cmd_data & `SICR_MASK_GND;
				default: ;
			endcase
		end
	end

	// Reply loaded one cycle after word end, once a write has landed,
	// so the next frame returns the new value, not the stale one
	logic reply_load;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reply_load <= 1'b0;
			reply      <= 32'h0000_0000;
		end else begin
			reply_load <= word_done;
			if (reply_load) begin
				reply <= {cmd_addr, cmd_wr, read_reg(cmd_addr)};
			end
		end
	end

	// Transmit shifter, MSB first, changes on falling SCLK
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_shift   <= 32'h0000_0000;
			spi_miso_o <= 1'b0;
		end else if (cs_fall) begin
			tx_shift   <= {reply[30:0], 1'b0};
			spi_miso_o <= reply[31];
		end else if (!cs_n_s && sclk_fall) begin
			tx_shift   <= {tx_shift[30:0], 1'b0};
			spi_miso_o <= tx_shift[31];
		end
	end

	// Global option decode
	wire logic ov_limit = ov_s & ~reg_global[`SICR_BIT_OV_BYPASS];
	wire logic [NUM_IN-1:0] tri_all = {reg_tri_g[13:0], reg_tri_p[7:0]};
	wire logic [NUM_IN-1:0] cont_all = {reg_cont_g[13:0], reg_cont_p[7:0]};
	wire logic [71:0] lvl_flat = {reg_wet_gh, reg_wet_gl, reg_wet_p};

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			analog_mux_mode_o   <= SICR_MUX_SPI0;
			switch_to_battery_o <= 8'hff;
			low_power_allow_o   <= 1'b0;
		end else begin
			analog_mux_mode_o <= sicr_mux_e'(
				reg_global[`SICR_BIT_MUX_HI:`SICR_BIT_MUX_LO]);
			switch_to_battery_o <= reg_global[7:0];
			low_power_allow_o   <= low_power_req_i & ~ov_limit;
		end
	end

	// Wake pin: falling edge wakes in low power unless check is off and rail is low
	wire logic wake_fall = ~wake_s & wake_q;
	wire logic poll_end  = ~poll_s & poll_q;
	logic [NUM_IN-1:0] poll_snap;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_req_o <= 1'b0;
			poll_snap  <= '0;
		end else begin
			wake_req_o <= lps_s && ((wake_fall &&
				(reg_global[`SICR_BIT_WAKE_CHECK] || rail_s))
				|| (poll_end && (cmp_b != poll_snap)));
			if (poll_end) begin
				poll_snap <= cmp_b;
			end
		end
	end

	// Interrupt pin: latched low or fixed-width low pulse
	logic [4:0] irq_cnt;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_cnt        <= 5'h00;
			irq_pin_o      <= 1'b0;
			irq_pin_oe_n_o <= 1'b1;
		end else begin
			if (irq_event_i) begin
				// Event cycle itself is the first low cycle of the pulse
				irq_cnt <= 5'(`SICR_IRQ_PULSE_CYC - 1);
			end else if (irq_cnt != 5'h00 &&
				reg_global[`SICR_BIT_IRQ_PULSE]) begin
				irq_cnt <= irq_cnt - 5'h01;
			end
			irq_pin_oe_n_o <= ~(irq_event_i || irq_cnt != 5'h00);
		end
	end

	// Per-input wetting timer and source drive
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_in
			logic [TW-1:0] tmr;
			logic          cmp_q;
			logic          expired;
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					tmr     <= '0;
					cmp_q   <= 1'b0;
					expired <= 1'b0;
				end else begin
					cmp_q <= cmp_b[gi];
					if (cmp_b[gi] != cmp_q) begin
						tmr     <= TW'(WET_CYC);
						expired <= 1'b0;
					end else if (tmr == TW'(1)) begin
						tmr     <= '0;
						expired <= 1'b1;
					end else if (tmr != '0) begin
						tmr <= tmr - TW'(1);
					end
				end
			end
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					source_on_o[gi] <= 1'b0;
					level_o[gi]     <= `SICR_LVL_LOW;
				end else begin
					source_on_o[gi] <= ~tri_all[gi];
					if (ov_limit) begin
						level_o[gi] <= `SICR_LVL_LOW;
					end else if (expired && !cont_all[gi]) begin
						level_o[gi] <= `SICR_LVL_LOW;
					end else begin
						level_o[gi] <= lvl_flat[3*gi +: 3];
					end
				end
			end
		end
	endgenerate

	// Checks
	wire logic [5:0] reg_gh_unused = reg_wet_gh[23:18];
	a_ov_blocks_lp: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) ov_limit |=> !low_power_allow_o)
		else $error("low power allowed under overvoltage");
	a_tri_source: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) tri_all[0] |=> !source_on_o[0])
		else $error("tri-stated input source on");
	a_mux_follow: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		1'b1 |=> analog_mux_mode_o == $past(reg_global[9:8]))
		else $error("mux mode mismatch");
	a_polarity: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		1'b1 |=> switch_to_battery_o == $past(reg_global[7:0]))
		else $error("polarity mismatch");
	a_wake_ignored: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) (wake_fall && !reg_global[11] && !rail_s
		&& !poll_end) |=> !wake_req_o)
		else $error("wake pin not ignored");
	a_wake_taken: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) (wake_fall && reg_global[11] && lps_s)
		|=> wake_req_o)
		else $error("wake edge missed");
	a_ghi_unused: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) reg_gh_unused == 6'h00)
		else $error("unused level bits set");
	a_ov_level: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) ov_limit |=> level_o[0] == 3'h0)
		else $error("level not capped");
	a_irq_latch: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) (irq_cnt != 5'h00 && !reg_global[10]
		&& !word_done && !irq_event_i) |=> irq_cnt == $past(irq_cnt))
		else $error("latched interrupt released");
	a_reply_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) (word_done && cmd_wr) |=>
		##1 reply[31:25] == $past(cmd_addr, 2))
		else $error("reply address wrong");
	a_reply_data: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) (word_done && cmd_wr &&
		cmd_addr == `SICR_ADDR_WET_PROG) |=>
		##1 reply[23:0] == $past(cmd_data, 2))
		else $error("reply data not the new value");
	c_write: cover property (@(posedge clk_sys_i) word_done && cmd_wr);
	c_expire: cover property (@(posedge clk_sys_i) g_in[0].expired);
	c_wake: cover property (@(posedge clk_sys_i) wake_req_o);
	c_ov: cover property (@(posedge clk_sys_i) ov_limit);
endmodule : sicr_regs
`default_nettype wire

// ===== pkg/sicr_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SICR_MAP_SVH
`define SICR_MAP_SVH
`define SICR_ADDR_GLOBAL      7'h01
`define SICR_ADDR_TRI_PROG    7'h02
`define SICR_ADDR_TRI_GND     7'h03
`define SICR_ADDR_WET_PROG    7'h04
`define SICR_ADDR_WET_GLO     7'h05
`define SICR_ADDR_WET_GHI     7'h06
`define SICR_ADDR_CONT_PROG   7'h0b
`define SICR_ADDR_CONT_GND    7'h0c
`define SICR_RST_GLOBAL       24'h00_08ff
`define SICR_RST_TRI_PROG     24'h00_00ff
`define SICR_RST_TRI_GND      24'h00_3fff
`define SICR_RST_WET          24'hdb_6db6
`define SICR_RST_WET_GHI      24'h03_6db6
`define SICR_RST_CONT         24'h00_0000
`define SICR_MASK_GLOBAL      24'h00_3fff
`define SICR_MASK_PROG        24'h00_00ff
`define SICR_MASK_GND         24'h00_3fff
`define SICR_MASK_WET_GHI     24'h03_ffff
`define SICR_BIT_OV_BYPASS    12
`define SICR_BIT_WAKE_CHECK   11
`define SICR_BIT_IRQ_PULSE    10
`define SICR_BIT_MUX_HI       9
`define SICR_BIT_MUX_LO       8
`define SICR_LVL_LOW          3'h0
`define SICR_WET_TIME_MS      20
`define SICR_CLK_MHZ          100
`define SICR_WET_CYCLES       (`SICR_WET_TIME_MS * 1000 * `SICR_CLK_MHZ)
`define SICR_IRQ_PULSE_CYC    16
`define SICR_SPI_CHECK_WORD   24'h12_3456
`endif

// ===== pkg/sicr_pkg.sv
// Types shared by the switch input configuration bank
package sicr_pkg;
	typedef enum logic [1:0] {
		SICR_MUX_SPI0,
		SICR_MUX_SPI1,
		SICR_MUX_HW2,
		SICR_MUX_HW3
	} sicr_mux_e;
	typedef logic [2:0] sicr_level_t;
endpackage : sicr_pkg

// ===== testbench/sicr_spi_master.sv
// SPI master model: 32-bit mode 0 frames, MSB first
`timescale 1ns/10ps
`default_nettype none
module sicr_spi_master (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// Clock parks low and select high between frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Whole word per frame; a short frame would be thrown away
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		for (int i = 31; i >= 0; i--) begin
			cs_n_o = 1'b0;
			mosi_o = tx[i];
			#80 sclk_o = 1'b1;
			rx[i] = miso_i;
			#80 sclk_o = 1'b0;
		end
		#80 cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line must not keep its value
		#200;
	endtask : xfer
endmodule : sicr_spi_master
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the switch input configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sicr_pkg::*;
	localparam int NI = 22;
	localparam int WC = 50;
	logic          clk_sys_i = 1'b0;
	logic          rst_n_i   = 1'b0;
	wire logic     sclk, cs_n, mosi;
	logic          miso, irq, irq_oe_n, wake, lp_ok;
	logic [NI-1:0] cmp  = '0;
	logic          ov   = 1'b0;
	logic          rail = 1'b1;
	logic          lps  = 1'b0;
	logic          lpr  = 1'b0;
	logic          poll = 1'b0;
	logic          wpin = 1'b1;
	logic          iev  = 1'b0;
	sicr_mux_e     mux;
	logic [7:0]    sb;
	logic [NI-1:0] src;
	sicr_level_t   lvl [NI];
	logic [23:0]   mdl [int];
	logic [23:0]   msk [int];
	logic [31:0]   seed = 32'h0000_60c0;
	int            n_fail = 0;
	int            cmp_count = 0;
	int            cnt;
	int            ad [8] = '{1, 2, 3, 4, 5, 6, 11, 12};
	logic [23:0]   rv [8] = '{24'h00_08ff, 24'h00_00ff, 24'h00_3fff,
		24'hdb_6db6, 24'hdb_6db6, 24'h03_6db6, 24'h00_0000, 24'h00_0000};
	logic [23:0]   mk [8] = '{24'h00_3fff, 24'h00_00ff, 24'h00_3fff,
		24'hff_ffff, 24'hff_ffff, 24'h03_ffff, 24'h00_00ff, 24'h00_3fff};

	always #5 clk_sys_i = ~clk_sys_i;

	sicr_spi_master m (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso));
	sicr_regs #(.NUM_IN(NI), .WET_CYC(WC)) dut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .switch_cmp_i(cmp),
		.battery_overvoltage_i(ov), .io_supply_rail_i(rail),
		.low_power_state_i(lps), .low_power_req_i(lpr),
		.poll_active_i(poll), .wake_pin_i(wpin), .irq_event_i(iev),
		.irq_pin_o(irq), .irq_pin_oe_n_o(irq_oe_n), .wake_req_o(wake),
		.low_power_allow_o(lp_ok), .analog_mux_mode_o(mux),
		.switch_to_battery_o(sb), .source_on_o(src), .level_o(lvl));

	// Xorshift keeps the run repeatable
	function automatic logic [23:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[23:0];
	endfunction : rnd

	// Wetting field of input i, prog inputs first
	function automatic logic [2:0] fld(input int i);
		int a;
		a = i < 8 ? 4 : (i < 16 ? 5 : 6);
		return mdl[a][3 * (i - (a - 4) * 8) +: 3];
	endfunction : fld

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc

	task automatic mdl_rst();
		foreach (ad[k]) begin
			mdl[ad[k]] = rv[k];
			msk[ad[k]] = mk[k];
		end
	endtask : mdl_rst

	// Access, then a dummy frame to pull back the reply
	task automatic acc(input logic [6:0] a, input logic w,
		input logic [23:0] d);
		logic [31:0] r;
		bit          hit;
		hit = mdl.exists(a);
		if (w && hit) mdl[a] = d & msk[a];
		m.xfer({a, w, d}, r);
		m.xfer(32'h0000_0000, r);
		if (hit) chk("reply", {a, w, mdl[a]}, r);
	endtask : acc

	task automatic ports(input bit lv);
		chk("sb", mdl[1][7:0], sb);
		chk("mux", mdl[1][9:8], mux);
		chk("src", {~mdl[3][13:0], ~mdl[2][7:0]}, src);
		if (lv) for (int i = 0; i < NI; i++) chk("lvl", fld(i), lvl[i]);
	endtask : ports

	task automatic see_wake(input bit want);
		bit hit;
		hit = 1'b0;
		repeat (20) begin
			cyc(1);
			if (wake === 1'b1) hit = 1'b1;
		end
		chk("wake", want, hit);
	endtask : see_wake

	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask : done

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	// Main sequence; every drive lands 1 ns after a rising edge
	initial begin
		mdl_rst();
		cyc(16);
		rst_n_i = 1'b1;
		cyc(8);
		foreach (ad[k]) acc(ad[k], 1'b0, 24'h00_0000);
		ports(1'b0);
		done("reset values");
		// Random data also proves unused bits read back as zero
		for (int n = 0; n < 3; n++) begin
			foreach (ad[k]) acc(ad[k], 1'b1, rnd());
			acc(7'h0d, 1'b1, rnd());
			foreach (ad[k]) acc(ad[k], 1'b0, 24'h00_0000);
			cyc(4);
			ports(1'b0);
		end
		for (int c = 0; c < 4; c++) begin
			acc(1, 1'b1, (mdl[1] & 24'hff_fcff) | (c << 8));
			cyc(4);
			ports(1'b0);
		end
		done("random access");
		// Every level code, then full current with continuous bits set
		acc(4, 1'b1, 24'hfa_c688);
		acc(5, 1'b1, 24'hfa_c688);
		acc(11, 1'b1, 24'h00_00ff);
		acc(12, 1'b1, 24'h00_3fff);
		cyc(4);
		ports(1'b1);
		acc(11, 1'b1, 24'h00_0000);
		cyc(1);
		// Inputs 7 and 15 carry code 111, so a drop to 000 is visible
		cmp[7] = ~cmp[7];
		cmp[15] = ~cmp[15];
		cyc(8);
		chk("wet on", fld(7), lvl[7]);
		cyc(WC + 10);
		chk("sustain", 3'h0, lvl[7]);
		chk("cont", fld(15), lvl[15]);
		acc(11, 1'b1, 24'h00_00ff);
		done("wetting");
		cyc(1);
		ov = 1'b1;
		lpr = 1'b1;
		acc(1, 1'b1, mdl[1] & 24'hff_efff);
		cyc(4);
		chk("lp allow", 1'b0, lp_ok);
		for (int i = 0; i < NI; i++) chk("cap", 3'h0, lvl[i]);
		acc(1, 1'b1, mdl[1] | 24'h00_1000);
		cyc(4);
		chk("lp allow", 1'b1, lp_ok);
		ports(1'b1);
		ov = 1'b0;
		done("overvoltage");
		lps = 1'b1;
		rail = 1'b0;
		acc(1, 1'b1, mdl[1] | 24'h00_0800);
		cyc(1);
		wpin = 1'b0;
		see_wake(1'b1);
		wpin = 1'b1;
		acc(1, 1'b1, mdl[1] & 24'hff_f7ff);
		cyc(1);
		wpin = 1'b0;
		see_wake(1'b0);
		wpin = 1'b1;
		rail = 1'b1;
		done("wake pin");
		acc(2, 1'b1, 24'h00_00ff);
		for (int p = 0; p < 3; p++) begin
			cyc(1);
			cmp = (p == 2) ? ~cmp : cmp;
			cyc(2);
			poll = 1'b1;
			cyc(6);
			chk("poll src", 8'h00, src[7:0]);
			poll = 1'b0;
			if (p > 0) see_wake(p == 2);
			else cyc(20);
		end
		lps = 1'b0;
		done("polling");
		acc(1, 1'b1, mdl[1] | 24'h00_0400);
		for (int s = 0; s < 2; s++) begin
			cyc(1);
			iev = 1'b1;
			cnt = 0;
			// Counting starts at the edge that takes the event
			repeat (40) begin
				cyc(1);
				iev = 1'b0;
				if (irq_oe_n === 1'b0) cnt++;
			end
			chk("irq low", s ? 40 : 16, cnt);
			chk("irq pin", 1'b0, irq);
			acc(1, 1'b1, mdl[1] & 24'hff_fbff);
		end
		rst_n_i = 1'b0;
		cyc(2);
		rst_n_i = 1'b1;
		mdl_rst();
		cyc(8);
		chk("irq idle", 1'b1, irq_oe_n);
		foreach (ad[k]) acc(ad[k], 1'b0, 24'h00_0000);
		done("interrupt and second reset");
		close_out();
	end
endmodule : tb
`default_nettype wire
